//--- core/ssp_defines.svh
// Register indices, field positions, reset values and timing counts of the simple serial port.
// Assumes an 8-bit APB address with one 32-bit word per register.
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

// Register indices; byte address is four times the index
`define SSP_IDX_CONTROL 8'h0a
`define SSP_IDX_STATUS 8'h0b
`define SSP_IDX_DATA 8'h0c
`define SSP_IDX_PINS 8'h0d
`define SSP_ADDR_CONTROL 8'(`SSP_IDX_CONTROL * 4)
`define SSP_ADDR_STATUS 8'(`SSP_IDX_STATUS * 4)
`define SSP_ADDR_DATA 8'(`SSP_IDX_DATA * 4)
`define SSP_ADDR_PINS 8'(`SSP_IDX_PINS * 4)

// Control fields
`define SSP_CTRL_EN_BIT 6
`define SSP_CTRL_MASTER_SELECT_BIT 4
`define SSP_CTRL_RESET 8'h00

// Status fields
`define SSP_STAT_TC_BIT 7
`define SSP_STAT_COL_BIT 6
`define SSP_STAT_RESET 8'h00

// Pin state register: data bits low nibble, direction bits high nibble
`define SSP_PIN_SCK 0
`define SSP_PIN_SDI 1
`define SSP_PIN_SDO 2
`define SSP_PINS_DIR_OFS 4
`define SSP_PINS_RESET 8'h00

`define SSP_DATA_RESET 8'h00

// Serial clock is the internal clock divided by this figure
`define SSP_SCK_DIV 4
`define SSP_SCK_FALL_PHASE 2'h0
`define SSP_SCK_RISE_PHASE 2'h2
`define SSP_BITS_PER_XFER 8
`define SSP_LAST_BIT 3'h7

// Stop exit recovery, in oscillator cycles, and its count in internal clocks
`define SSP_STOP_OSC_CYCLES 4064
`define SSP_OSC_PER_CLK 2
`define SSP_STOP_CLKS (`SSP_STOP_OSC_CYCLES / `SSP_OSC_PER_CLK)
`define SSP_RECOV_W 11

`endif

//--- core/ssp_pkg.sv
// Types shared by the simple serial port files.
// Constants live in ssp_defines.svh.
package ssp_pkg;

  typedef enum logic {XFER_IDLE, XFER_SHIFT} xfer_state_t;

endpackage

//--- core/ssp_sync2.sv
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/10ps
module ssp_sync2
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_r;

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      meta_r <= 1'b1;
      sync_out <= 1'b1;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

//--- core/ssp_sck_div.sv
// Master serial clock divider: one falling and one rising pulse per four clocks.
// Assumes run rises at transfer start; the first cycle of run yields the falling pulse.
`timescale 1ns/10ps
`include "ssp_defines.svh"
module ssp_sck_div
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic run,
  output logic fall_pulse,
  output logic rise_pulse
);

  logic [1:0] phase_r;
  logic [1:0] phase_nxt;

  assign phase_nxt = run ? phase_r + 2'h1 : 2'h0;
  assign fall_pulse = run && (phase_r == `SSP_SCK_FALL_PHASE);
  assign rise_pulse = run && (phase_r == `SSP_SCK_RISE_PHASE);

  always_ff @(posedge clk)
  begin
    if (!rstn)
      phase_r <= 2'h0;
    else
      phase_r <= phase_nxt;
  end

endmodule

//--- core/simple_serial_port.sv
// Simple synchronous serial port: one shared shift/data register, master or slave, APB registers.
// Assumes APB master on CLK; serial pins are asynchronous and are synchronised here.
`timescale 1ns/10ps
`include "ssp_defines.svh"
module simple_serial_port
#(
  parameter bit LSB_FIRST = 1'b0
)
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic STOP_MODE,
  input wire logic WAIT_MODE,
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE_N,
  input wire logic SDI_I,
  output logic SDI_O,
  output logic SDI_OE_N,
  output logic SDO_O,
  output logic SDO_OE_N,
  output logic PORT_OWNED
);

  // Register state
  logic en_r;
  logic en_nxt;
  logic master_select_r;
  logic master_select_nxt;
  logic tc_r;
  logic tc_nxt;
  logic col_r;
  logic col_nxt;
  logic armed_r;
  logic armed_nxt;
  logic [7:0] data_r;
  logic [7:0] data_nxt;
  logic [7:0] pins_r;
  logic [7:0] pins_nxt;
  logic [31:0] prdata_r;
  ssp_pkg::xfer_state_t state_r;
  ssp_pkg::xfer_state_t state_nxt;
  logic [2:0] bit_cnt_r;
  logic [2:0] bit_cnt_nxt;
  logic [`SSP_RECOV_W-1:0] recov_r;
  logic [`SSP_RECOV_W-1:0] recov_nxt;
  logic stop_d_r;
  logic sck_d_r;

  // Bus decode
  wire setup = PSEL && !PENABLE;
  wire access = PSEL && PENABLE;
  wire hit_ctrl = (PADDR == `SSP_ADDR_CONTROL);
  wire hit_stat = (PADDR == `SSP_ADDR_STATUS);
  wire hit_data = (PADDR == `SSP_ADDR_DATA);
  wire hit_pins = (PADDR == `SSP_ADDR_PINS);
  wire hit_any = hit_ctrl || hit_stat || hit_data || hit_pins;
  wire wr_ctrl = access && PWRITE && hit_ctrl;
  wire wr_data = access && PWRITE && hit_data;
  wire wr_pins = access && PWRITE && hit_pins;
  wire rd_stat = access && !PWRITE && hit_stat;
  wire data_access = access && hit_data;
  wire [7:0] ctrl_val = 8'((8'(en_r) << `SSP_CTRL_EN_BIT) | (8'(master_select_r) << `SSP_CTRL_MASTER_SELECT_BIT));
  wire [7:0] stat_val = 8'((8'(tc_r) << `SSP_STAT_TC_BIT) | (8'(col_r) << `SSP_STAT_COL_BIT));
  wire [7:0] rd_mux = hit_ctrl ? ctrl_val :
                      hit_stat ? stat_val :
                      hit_data ? data_r :
                      hit_pins ? pins_r : 8'h00;
  wire wr_en_bit = PWDATA[`SSP_CTRL_EN_BIT];

  assign PREADY = 1'b1;
  assign PSLVERR = access && !hit_any;
  assign PRDATA = prdata_r;

  // Low-power halt: stop and wait freeze the port, stop exit adds recovery
  wire stop_exit = stop_d_r && !STOP_MODE;
  wire halted = STOP_MODE || WAIT_MODE || (recov_r != `SSP_RECOV_W'(0));
  assign recov_nxt = stop_exit ? `SSP_RECOV_W'(`SSP_STOP_CLKS) :
                     (recov_r != `SSP_RECOV_W'(0)) ? recov_r - `SSP_RECOV_W'(1) : recov_r;

  // Serial pin inputs
  logic sck_s;
  logic sdi_s;

  ssp_sync2 u_sync_sck
  (
    .clk(CLK),
    .rstn(RSTN),
    .async_in(SCK_I),
    .sync_out(sck_s)
  );

  ssp_sync2 u_sync_sdi
  (
    .clk(CLK),
    .rstn(RSTN),
    .async_in(SDI_I),
    .sync_out(sdi_s)
  );

  // Master clock generation
  wire busy = (state_r == ssp_pkg::XFER_SHIFT);
  wire m_run = en_r && master_select_r && busy && !halted;
  logic m_fall;
  logic m_rise;

  ssp_sck_div u_sck_div
  (
    .clk(CLK),
    .rstn(RSTN),
    .run(m_run),
    .fall_pulse(m_fall),
    .rise_pulse(m_rise)
  );

  // Slave edges from the synchronised external clock
  wire s_act = en_r && !master_select_r && !halted;
  wire s_fall = s_act && sck_d_r && !sck_s;
  wire s_rise = s_act && busy && !sck_d_r && sck_s;
  wire fall_ev = master_select_r ? m_fall : s_fall;
  wire rise_ev = master_select_r ? m_rise : s_rise;
  wire last_rise = rise_ev && (bit_cnt_r == `SSP_LAST_BIT);
  wire m_start = wr_data && master_select_r && en_r && !busy;

  wire out_bit = LSB_FIRST ? data_r[0] : data_r[7];
  wire [7:0] shifted = LSB_FIRST ? {sdi_s, data_r[7:1]} : {data_r[6:0], sdi_s};

  // Transfer sequencing
  always_comb
  begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    if (!en_r)
    begin
      state_nxt = ssp_pkg::XFER_IDLE;
      bit_cnt_nxt = 3'h0;
    end
    else
    begin
      case (state_r)
        ssp_pkg::XFER_IDLE:
        begin
          bit_cnt_nxt = 3'h0;
          if (m_start || (!master_select_r && s_fall))
            state_nxt = ssp_pkg::XFER_SHIFT;
        end
        ssp_pkg::XFER_SHIFT:
        begin
          if (rise_ev)
            bit_cnt_nxt = bit_cnt_r + 3'h1;
          if (last_rise)
            state_nxt = ssp_pkg::XFER_IDLE;
        end
        default:
        begin
          state_nxt = ssp_pkg::XFER_IDLE;
          bit_cnt_nxt = 3'h0;
        end
      endcase
    end
  end

  // Shared transmit/receive register; a bus write wins over a shift
  always_comb
  begin
    data_nxt = data_r;
    if (wr_data)
      data_nxt = PWDATA[7:0];
    else if (busy && rise_ev)
      data_nxt = shifted;
  end

  // Control register
  always_comb
  begin
    en_nxt = en_r;
    master_select_nxt = master_select_r;
    if (wr_ctrl)
    begin
      en_nxt = wr_en_bit;
      master_select_nxt = PWDATA[`SSP_CTRL_MASTER_SELECT_BIT];
    end
  end

  // Status flags: hardware set wins over software clear
  wire clr_seq = data_access && armed_r;
  wire col_set = data_access && busy;
  wire en_toggle_on = wr_ctrl && wr_en_bit && !en_r && !tc_r;
  assign tc_nxt = last_rise || (tc_r && !clr_seq);
  assign col_nxt = col_set || (col_r && !(clr_seq || en_toggle_on));
  assign armed_nxt = rd_stat ? prdata_r[`SSP_STAT_TC_BIT] : (armed_r && !data_access);

  // Pin state: the port sets directions while enabled and they persist afterwards
  always_comb
  begin
    pins_nxt = pins_r;
    if (wr_pins && !en_r)
      pins_nxt = PWDATA[7:0];
    if (en_r)
    begin
      pins_nxt[`SSP_PINS_DIR_OFS + `SSP_PIN_SCK] = master_select_r;
      pins_nxt[`SSP_PINS_DIR_OFS + `SSP_PIN_SDI] = 1'b0;
      pins_nxt[`SSP_PINS_DIR_OFS + `SSP_PIN_SDO] = 1'b1;
      if (master_select_r && !busy)
        pins_nxt[`SSP_PIN_SCK] = 1'b1;
      else if (master_select_r && m_fall)
        pins_nxt[`SSP_PIN_SCK] = 1'b0;
      else if (master_select_r && m_rise)
        pins_nxt[`SSP_PIN_SCK] = 1'b1;
      // A slave's starting fall arrives while idle and must already drive the first bit
      if (fall_ev && (busy || !master_select_r))
        pins_nxt[`SSP_PIN_SDO] = out_bit;
    end
  end

  // Pin drive: enabled port forces directions, otherwise held state applies
  wire sck_drive = en_r ? master_select_r : pins_r[`SSP_PINS_DIR_OFS + `SSP_PIN_SCK];
  wire sdi_drive = en_r ? 1'b0 : pins_r[`SSP_PINS_DIR_OFS + `SSP_PIN_SDI];
  wire sdo_drive = en_r ? 1'b1 : pins_r[`SSP_PINS_DIR_OFS + `SSP_PIN_SDO];

  assign SCK_O = pins_r[`SSP_PIN_SCK];
  assign SCK_OE_N = !sck_drive;
  assign SDI_O = pins_r[`SSP_PIN_SDI];
  assign SDI_OE_N = !sdi_drive;
  assign SDO_O = pins_r[`SSP_PIN_SDO];
  assign SDO_OE_N = !sdo_drive;
  assign PORT_OWNED = en_r;

  // Register updates; the port never raises an interrupt
  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      en_r <= 1'b0;
      master_select_r <= 1'b0;
      tc_r <= 1'b0;
      col_r <= 1'b0;
      armed_r <= 1'b0;
      data_r <= `SSP_DATA_RESET;
      pins_r <= `SSP_PINS_RESET;
      state_r <= ssp_pkg::XFER_IDLE;
      bit_cnt_r <= 3'h0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      en_r <= en_nxt;
      master_select_r <= master_select_nxt;
      tc_r <= tc_nxt;
      col_r <= col_nxt;
      armed_r <= armed_nxt;
      data_r <= data_nxt;
      pins_r <= pins_nxt;
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      if (setup && !PWRITE)
        prdata_r <= {24'h00_0000, rd_mux};
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RSTN)
    begin
      recov_r <= `SSP_RECOV_W'(0);
      stop_d_r <= 1'b0;
      sck_d_r <= 1'b1;
    end
    else
    begin
      recov_r <= recov_nxt;
      stop_d_r <= STOP_MODE;
      sck_d_r <= sck_s;
    end
  end

endmodule

//--- verif/ssp_properties.sv
// Port-level properties of the simple serial port.
// Assumes it is bound to simple_serial_port, one clock domain.
`timescale 1ns/10ps
`include "ssp_defines.svh"
module ssp_properties (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic STOP_MODE,
  input wire logic WAIT_MODE,
  input wire logic SCK_O,
  input wire logic SCK_OE_N,
  input wire logic SDI_OE_N,
  input wire logic SDO_O,
  input wire logic SDO_OE_N,
  input wire logic PORT_OWNED
);
  wire master_w = PORT_OWNED && !SCK_OE_N;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_sdi_input: assert property (PORT_OWNED |-> SDI_OE_N) else $error("sdi driven");
  a_sdo_output: assert property (PORT_OWNED |-> !SDO_OE_N) else $error("sdo not driven");
  a_sck_period:
    assert property (disable iff (!RSTN || WAIT_MODE || STOP_MODE || !PORT_OWNED)
      master_w && $fell(SCK_O) |=> !SCK_O ##1 SCK_O [*2]) else $error("sck period");
  a_sdo_on_fall:
    assert property (master_w && $changed(SDO_O) |-> $fell(SCK_O)) else $error("sdo moved off fall");
  a_dir_kept:
    assert property ($fell(PORT_OWNED) |-> $stable(SDO_OE_N) && $stable(SDI_OE_N) && $stable(SCK_OE_N))
      else $error("directions lost");
  a_status_zeros:
    assert property (PSEL && !PENABLE && !PWRITE && PADDR == `SSP_ADDR_STATUS
      |=> PRDATA[31:8] == 24'h0 && PRDATA[5:0] == 6'h0) else $error("status spare bits");
  a_reset_off:
    assert property (disable iff (1'b0) !RSTN |=> !PORT_OWNED && SDO_OE_N) else $error("enabled after reset");
  a_halt_freeze:
    assert property ((WAIT_MODE || STOP_MODE) && PORT_OWNED |=> $stable(SCK_O) && $stable(SDO_O))
      else $error("moved while halted");
  c_master: cover property (master_w && $fell(SCK_O));
  c_slave: cover property (PORT_OWNED && SCK_OE_N);
  c_halt: cover property (WAIT_MODE && PORT_OWNED);
endmodule

//--- verif/ssp_far_end.sv
// Far end of the serial link: shifts on the shared clock, or makes it.
// Assumes MSB first and a clock that idles high.
`timescale 1ns/10ps
module ssp_far_end (
  input wire logic sck_in,
  input wire logic sdo_in,
  output logic sck_out,
  output logic sdi_out
);
  logic [7:0] tx_r = 8'h00;
  logic [7:0] rx_r = 8'h00;
  int n = 0;
  initial
  begin
    sck_out = 1'b1;
    sdi_out = 1'b0;
  end
  task load(input logic [7:0] b);
    tx_r = b;
    rx_r = 8'h00;
    n = 0;
  endtask
  // Eight 320 ns periods, phase offset from the port clock
  task frame;
    #13;
    repeat (8)
    begin
      #160 sck_out = 1'b0;
      #160 sck_out = 1'b1;
    end
  endtask
  always @(negedge sck_in)
  begin
    sdi_out = tx_r[7];
    tx_r = {tx_r[6:0], 1'b0};
  end
  always @(posedge sck_in)
  begin
    rx_r = {rx_r[6:0], sdo_in};
    n++;
    if (n == 8)
    begin
      // Hold time over: line no longer shows the last bit
      #160 sdi_out = ~sdi_out;
    end
  end
endmodule

//--- verif/tb_top.sv
// Directed bench for the simple serial port over APB.
// Assumes the MSB-first build and the far-end model.
`timescale 1ns/10ps
`include "ssp_defines.svh"
module tb_top;
  logic CLK = 1'b0;
  logic RSTN = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic STOP_MODE = 1'b0;
  logic WAIT_MODE = 1'b0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, SCK_O, SCK_OE_N, SDI_O, SDI_OE_N, SDO_O, SDO_OE_N, PORT_OWNED;
  logic far_sck, far_sdi, sck_w, sdi_w, sdo_w;
  logic [7:0] q;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  assign sck_w = SCK_OE_N ? far_sck : SCK_O;
  assign sdi_w = SDI_OE_N ? far_sdi : SDI_O;
  assign sdo_w = SDO_OE_N ? 1'b1 : SDO_O;
  always #20 CLK = ~CLK;
  simple_serial_port i_dut (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .STOP_MODE(STOP_MODE), .WAIT_MODE(WAIT_MODE), .SCK_I(sck_w), .SCK_O(SCK_O), .SCK_OE_N(SCK_OE_N),
    .SDI_I(sdi_w), .SDI_O(SDI_O), .SDI_OE_N(SDI_OE_N), .SDO_O(SDO_O), .SDO_OE_N(SDO_OE_N),
    .PORT_OWNED(PORT_OWNED));
  ssp_far_end i_far (.sck_in(sck_w), .sdo_in(sdo_w), .sck_out(far_sck), .sdi_out(far_sdi));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1)
      @(posedge CLK);
    q = PRDATA[7:0];
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(q, e);
  endtask
  task wait_done;
    q = 8'h00;
    while (q[7] !== 1'b1)
      apb(1'b0, `SSP_ADDR_STATUS, 8'h00);
  endtask
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (5) @(posedge CLK);
    RSTN <= 1'b1;
    rd(`SSP_ADDR_STATUS, `SSP_STAT_RESET);
    rd(`SSP_ADDR_CONTROL, `SSP_CTRL_RESET);
    $display("test reset done");
    apb(1'b1, `SSP_ADDR_CONTROL, 8'h50);
    i_far.load(8'h3c);
    apb(1'b1, `SSP_ADDR_DATA, 8'ha5);
    repeat (10) @(posedge CLK);
    WAIT_MODE <= 1'b1;
    repeat (9) @(posedge CLK);
    WAIT_MODE <= 1'b0;
    wait_done;
    rd(`SSP_ADDR_STATUS, 8'h80);
    rd(`SSP_ADDR_DATA, 8'h3c);
    rd(`SSP_ADDR_STATUS, 8'h00);
    chk(i_far.rx_r, 8'ha5);
    rd(`SSP_ADDR_CONTROL, 8'h50);
    $display("test master done");
    i_far.load(8'h0f);
    apb(1'b1, `SSP_ADDR_DATA, 8'h11);
    apb(1'b1, `SSP_ADDR_DATA, 8'h22);
    wait_done;
    rd(`SSP_ADDR_STATUS, 8'hc0);
    apb(1'b1, `SSP_ADDR_DATA, 8'h77);
    apb(1'b0, `SSP_ADDR_DATA, 8'h00);
    rd(`SSP_ADDR_STATUS, 8'h40);
    apb(1'b1, `SSP_ADDR_CONTROL, 8'h10);
    repeat (40) @(posedge CLK);
    rd(`SSP_ADDR_STATUS, 8'h40);
    rd(`SSP_ADDR_CONTROL, 8'h10);
    apb(1'b0, `SSP_ADDR_PINS, 8'h00);
    chk(q & 8'h70, 8'h50);
    apb(1'b1, `SSP_ADDR_CONTROL, 8'h50);
    rd(`SSP_ADDR_STATUS, 8'h00);
    $display("test collision done");
    apb(1'b1, `SSP_ADDR_CONTROL, 8'h40);
    i_far.load(8'h5a);
    apb(1'b1, `SSP_ADDR_DATA, 8'h11);
    apb(1'b1, `SSP_ADDR_DATA, 8'h96);
    chk({7'h0, SCK_OE_N}, 8'h01);
    i_far.frame();
    wait_done;
    rd(`SSP_ADDR_DATA, 8'h5a);
    chk(i_far.rx_r, 8'h96);
    $display("test slave done");
    STOP_MODE <= 1'b1;
    repeat (3) @(posedge CLK);
    STOP_MODE <= 1'b0;
    repeat (3) @(posedge CLK);
    tally_and_finish;
  end
endmodule
bind simple_serial_port ssp_properties i_props (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .STOP_MODE(STOP_MODE), .WAIT_MODE(WAIT_MODE),
  .SCK_O(SCK_O), .SCK_OE_N(SCK_OE_N), .SDI_OE_N(SDI_OE_N), .SDO_O(SDO_O), .SDO_OE_N(SDO_OE_N),
  .PORT_OWNED(PORT_OWNED));
